// File: shared/pdfc_defs.svh
// Register indexes, field positions, reset values and decode constants
`ifndef PDFC_DEFS_SVH
`define PDFC_DEFS_SVH

// ----------------------------------------------------------------------
// Register indexes (byte address is four times the index)
// ----------------------------------------------------------------------
`define PDFC_IDX_RESET      8'h02
`define PDFC_IDX_FB_LOW     8'h10
`define PDFC_IDX_FB_MID     8'h11
`define PDFC_IDX_FB_HIGH    8'h12
`define PDFC_IDX_NUM0       8'h13
`define PDFC_IDX_NUM1       8'h14
`define PDFC_IDX_NUM2       8'h15
`define PDFC_IDX_DEN0       8'h16
`define PDFC_IDX_DEN1       8'h17
`define PDFC_IDX_DEN2       8'h18
`define PDFC_IDX_REF_LOW    8'h19
`define PDFC_IDX_REF_HIGH   8'h1a
`define PDFC_IDX_REF_OPT    8'h1b
`define PDFC_IDX_PUMP       8'h1c
`define PDFC_IDX_RAMP_CTL   8'h20
`define PDFC_IDX_STATUS     8'h21

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define PDFC_RST_FB         24'h000010
`define PDFC_RST_NUM        24'h000000
`define PDFC_RST_DEN        24'h000000
`define PDFC_RST_REF        16'h0001
`define PDFC_RST_REF_OPT    8'h08
`define PDFC_RST_PUMP       8'h00
`define PDFC_RST_RAMP_CTL   8'h00

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define PDFC_SOFTWARE_REGISTER_RESET_BIT      2
`define PDFC_FB_HI_MSB      1
`define PDFC_DITHER_LSB     2
`define PDFC_ORDER_LSB      4
`define PDFC_DOUBLER_BIT    0
`define PDFC_DIFF_BIT       2
`define PDFC_PULSE_LSB      3
`define PDFC_GAIN_MSB       4
`define PDFC_POLARITY_BIT   5
`define PDFC_RAMP_EN_BIT    0

// ----------------------------------------------------------------------
// Decode constants
// ----------------------------------------------------------------------
`define PDFC_ORDER_MAX      3'h4
`define PDFC_PULSE_PS_1     11'h35c
`define PDFC_PULSE_PS_2     11'h4b0
`define PDFC_PULSE_PS_3     11'h5dc
`define PDFC_PUMP_STEP_UA   12'h064
`define PDFC_RAMP_DEN       25'h1000000

`endif

// File: shared/pdfc_pkg.sv
// Types shared by the divider and fraction configuration block
package pdfc_pkg;

  // Dither strength as the modulator sees it
  typedef enum logic [1:0] {
    PDFC_DITHER_WEAK   = 2'b00,
    PDFC_DITHER_MEDIUM = 2'b01,
    PDFC_DITHER_STRONG = 2'b10,
    PDFC_DITHER_OFF    = 2'b11
  } pdfc_dither_t;

  // Settings presented to the synthesizer core
  typedef struct packed {
    logic [17:0]  feedback_divide;
    logic         ramp_start;
    pdfc_dither_t modulator_dither_level;
    logic         dither_enable;
    logic [2:0]   modulator_order_select;
    logic         integer_mode;
    logic         order_reserved;
    logic [23:0]  fraction_numerator;
    logic [24:0]  fraction_denominator;
    logic [15:0]  reference_divide;
    logic         reference_bypass;
    logic         reference_doubler_enable;
    logic         differential_reference_counter;
    logic [1:0]   detector_min_pulse_width;
    logic [10:0]  pulse_width_ps;
    logic         pulse_width_reserved;
    logic [4:0]   pump_current_gain;
    logic [11:0]  pump_current_ua;
    logic         pump_tristate;
    logic         pump_polarity_negative;
  } pdfc_core_t;

endpackage : pdfc_pkg

// File: verilog/pdfc_shadow.sv
// Staged multi-byte field that commits once every byte has been written
`timescale 1ns/10ps
`default_nettype none

module pdfc_shadow #(
  parameter int          NB    = 3,
  parameter logic [23:0] RST_V = 24'h000000
) (
  // Clock and reset
  input  wire logic          i_clk,
  input  wire logic          i_rst_n,
  // Write side
  input  wire logic          i_clear,
  input  wire logic          i_wr,
  input  wire logic [NB-1:0] i_byte_sel,
  input  wire logic [7:0]    i_wdata,
  // Staged bytes, committed value, pending flag
  output logic [8*NB-1:0]    o_stage,
  output logic [8*NB-1:0]    o_value,
  output logic               o_pending
);

  logic [8*NB-1:0] stage;
  logic [8*NB-1:0] next_stage;
  logic [8*NB-1:0] value;
  logic [8*NB-1:0] next_value;
  logic [NB-1:0]   mask;
  logic [NB-1:0]   next_mask;
  logic [NB-1:0]   mask_now;

  // ----------------------------------------------------------------------
  // Byte staging
  // ----------------------------------------------------------------------
  genvar gb;
  generate
    for (gb = 0; gb < NB; gb++) begin : g_byte
      // One driver per byte slice; lowest index is least significant
      assign next_stage[8*gb +: 8] =
        i_clear                  ? RST_V[8*gb +: 8] :
        (i_wr && i_byte_sel[gb]) ? i_wdata          :
                                   stage[8*gb +: 8];
    end
  endgenerate

  // Commit only when the last missing byte lands, so the core
  // never sees a half-updated field
  always_comb begin
    mask_now   = mask | (i_wr ? i_byte_sel : '0);
    next_mask  = mask_now;
    next_value = value;
    if (i_clear) begin
      next_mask  = '0;
      next_value = RST_V[8*NB-1:0];
    end else if (&mask_now) begin
      next_mask  = '0;
      next_value = next_stage;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      stage <= RST_V[8*NB-1:0];
      value <= RST_V[8*NB-1:0];
      mask  <= '0;
    end else begin
      stage <= next_stage;
      value <= next_value;
      mask  <= next_mask;
    end
  end

  assign o_stage   = stage;
  assign o_value   = value;
  assign o_pending = |mask;

endmodule : pdfc_shadow

`default_nettype wire

// File: verilog/pdfc_top.sv
// Divider and fractional configuration register bank on APB
//
// Behaviour
// - 18-bit feedback divide, three bytes, resets to 16
// - Low feedback byte write starts ramp execution
// - Decode dither levels and modulator order codes
// - Ramp mode forces denominator to two^24
// - 16-bit reference divide, default 1, 1 bypasses
// - Doubler bit enables reference doubler, reset off
// - Differential reference counter; software limits divides
// - Decode minimum pulse width, reset value 1
// - Pump gain 100 uA steps, polarity bit
// - Software reset bit restores all defaults
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "pdfc_defs.svh"

module pdfc_top (
  // Clock and reset
  input  wire logic                i_clk,
  input  wire logic                i_rst_n,
  // APB slave
  input  wire logic                i_psel,
  input  wire logic                i_penable,
  input  wire logic                i_pwrite,
  input  wire logic [11:0]         i_paddr,
  input  wire logic [31:0]         i_pwdata,
  output logic                     o_pready,
  output logic [31:0]              o_prdata,
  output logic                     o_pslverr,
  // Synthesizer core settings
  output pdfc_pkg::pdfc_core_t     o_core
);

  import pdfc_pkg::*;

  // ----------------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------------
  // Pulse width code to picoseconds; code 0 is reserved
  function automatic logic [10:0] pdfc_pulse_ps(input logic [1:0] code);
    logic [10:0] ps;
    ps = 11'h000;
    case (code)
      2'h1:    ps = `PDFC_PULSE_PS_1;
      2'h2:    ps = `PDFC_PULSE_PS_2;
      2'h3:    ps = `PDFC_PULSE_PS_3;
      default: ps = 11'h000;
    endcase
    return ps;
  endfunction : pdfc_pulse_ps

  // Index hit on a mapped register
  function automatic logic pdfc_mapped(input logic [7:0] idx);
    logic hit;
    hit = 1'b0;
    case (idx)
      `PDFC_IDX_RESET, `PDFC_IDX_FB_LOW, `PDFC_IDX_FB_MID,
      `PDFC_IDX_FB_HIGH, `PDFC_IDX_NUM0, `PDFC_IDX_NUM1,
      `PDFC_IDX_NUM2, `PDFC_IDX_DEN0, `PDFC_IDX_DEN1,
      `PDFC_IDX_DEN2, `PDFC_IDX_REF_LOW, `PDFC_IDX_REF_HIGH,
      `PDFC_IDX_REF_OPT, `PDFC_IDX_PUMP, `PDFC_IDX_RAMP_CTL,
      `PDFC_IDX_STATUS: hit = 1'b1;
      default:          hit = 1'b0;
    endcase
    return hit;
  endfunction : pdfc_mapped

  // ----------------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------------
  logic [7:0]  idx;
  logic        aligned;
  logic        hit;
  logic        take;
  logic        wr;
  logic [7:0]  wbyte;
  logic        sw_clear;

  // Bits above the index and the byte offset must be zero
  assign idx     = i_paddr[9:2];
  assign aligned = (i_paddr[11:10] == 2'h0) && (i_paddr[1:0] == 2'h0);
  assign hit     = aligned && pdfc_mapped(idx);
  // The write lands on the edge where pready is sampled high
  assign take    = i_psel && i_penable && o_pready;
  assign wr      = take && i_pwrite && hit;
  assign wbyte   = i_pwdata[7:0];

  // Self-clearing software reset, reads back as zero
  assign sw_clear = wr && (idx == `PDFC_IDX_RESET) &&
                    wbyte[`PDFC_SOFTWARE_REGISTER_RESET_BIT];

  // ----------------------------------------------------------------------
  // Multi-byte fields
  // ----------------------------------------------------------------------
  logic [23:0] fb_stage;
  logic [23:0] fb_value;
  logic        fb_pend;
  logic [23:0] num_stage;
  logic [23:0] num_value;
  logic        num_pend;
  logic [23:0] den_stage;
  logic [23:0] den_value;
  logic        den_pend;
  logic [15:0] ref_stage;
  logic [15:0] ref_value;
  logic        ref_pend;

  // Feedback divide plus the modulator fields share the top byte
  pdfc_shadow #(
    .NB    (3),
    .RST_V (`PDFC_RST_FB)
  ) u_fb (
    .i_clk      (i_clk),
    .i_rst_n    (i_rst_n),
    .i_clear    (sw_clear),
    .i_wr       (wr),
    .i_byte_sel ({idx == `PDFC_IDX_FB_HIGH, idx == `PDFC_IDX_FB_MID,
                  idx == `PDFC_IDX_FB_LOW}),
    .i_wdata    (wbyte),
    .o_stage    (fb_stage),
    .o_value    (fb_value),
    .o_pending  (fb_pend)
  );

  pdfc_shadow #(
    .NB    (3),
    .RST_V (`PDFC_RST_NUM)
  ) u_num (
    .i_clk      (i_clk),
    .i_rst_n    (i_rst_n),
    .i_clear    (sw_clear),
    .i_wr       (wr),
    .i_byte_sel ({idx == `PDFC_IDX_NUM2, idx == `PDFC_IDX_NUM1,
                  idx == `PDFC_IDX_NUM0}),
    .i_wdata    (wbyte),
    .o_stage    (num_stage),
    .o_value    (num_value),
    .o_pending  (num_pend)
  );

  pdfc_shadow #(
    .NB    (3),
    .RST_V (`PDFC_RST_DEN)
  ) u_den (
    .i_clk      (i_clk),
    .i_rst_n    (i_rst_n),
    .i_clear    (sw_clear),
    .i_wr       (wr),
    .i_byte_sel ({idx == `PDFC_IDX_DEN2, idx == `PDFC_IDX_DEN1,
                  idx == `PDFC_IDX_DEN0}),
    .i_wdata    (wbyte),
    .o_stage    (den_stage),
    .o_value    (den_value),
    .o_pending  (den_pend)
  );

  pdfc_shadow #(
    .NB    (2),
    .RST_V ({8'h00, `PDFC_RST_REF})
  ) u_ref (
    .i_clk      (i_clk),
    .i_rst_n    (i_rst_n),
    .i_clear    (sw_clear),
    .i_wr       (wr),
    .i_byte_sel ({idx == `PDFC_IDX_REF_HIGH, idx == `PDFC_IDX_REF_LOW}),
    .i_wdata    (wbyte),
    .o_stage    (ref_stage),
    .o_value    (ref_value),
    .o_pending  (ref_pend)
  );

  // ----------------------------------------------------------------------
  // Single-byte registers
  // ----------------------------------------------------------------------
  logic [7:0] ref_opt;
  logic [7:0] next_ref_opt;
  logic [7:0] pump;
  logic [7:0] next_pump;
  logic [7:0] ramp_ctl;
  logic [7:0] next_ramp_ctl;

  // Software reset wins over a write in the same cycle
  always_comb begin
    next_ref_opt  = ref_opt;
    next_pump     = pump;
    next_ramp_ctl = ramp_ctl;
    if (sw_clear) begin
      next_ref_opt  = `PDFC_RST_REF_OPT;
      next_pump     = `PDFC_RST_PUMP;
      next_ramp_ctl = `PDFC_RST_RAMP_CTL;
    end else if (wr) begin
      if (idx == `PDFC_IDX_REF_OPT) begin
        next_ref_opt = wbyte;
      end
      if (idx == `PDFC_IDX_PUMP) begin
        next_pump = wbyte;
      end
      if (idx == `PDFC_IDX_RAMP_CTL) begin
        next_ramp_ctl = wbyte;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ref_opt  <= `PDFC_RST_REF_OPT;
      pump     <= `PDFC_RST_PUMP;
      ramp_ctl <= `PDFC_RST_RAMP_CTL;
    end else begin
      ref_opt  <= next_ref_opt;
      pump     <= next_pump;
      ramp_ctl <= next_ramp_ctl;
    end
  end

  // ----------------------------------------------------------------------
  // APB answer
  // ----------------------------------------------------------------------
  logic        next_pready;
  logic [31:0] next_prdata;
  logic        next_pslverr;
  logic [7:0]  rbyte;

  // Read mux over staged bytes so software sees what it wrote
  always_comb begin
    rbyte = 8'h00;
    case (idx)
      `PDFC_IDX_FB_LOW:   rbyte = fb_stage[7:0];
      `PDFC_IDX_FB_MID:   rbyte = fb_stage[15:8];
      `PDFC_IDX_FB_HIGH:  rbyte = fb_stage[23:16];
      `PDFC_IDX_NUM0:     rbyte = num_stage[7:0];
      `PDFC_IDX_NUM1:     rbyte = num_stage[15:8];
      `PDFC_IDX_NUM2:     rbyte = num_stage[23:16];
      `PDFC_IDX_DEN0:     rbyte = den_stage[7:0];
      `PDFC_IDX_DEN1:     rbyte = den_stage[15:8];
      `PDFC_IDX_DEN2:     rbyte = den_stage[23:16];
      `PDFC_IDX_REF_LOW:  rbyte = ref_stage[7:0];
      `PDFC_IDX_REF_HIGH: rbyte = ref_stage[15:8];
      `PDFC_IDX_REF_OPT:  rbyte = ref_opt;
      `PDFC_IDX_PUMP:     rbyte = pump;
      `PDFC_IDX_RAMP_CTL: rbyte = ramp_ctl;
      `PDFC_IDX_STATUS:   rbyte = {4'h0, ref_pend, den_pend,
                                   num_pend, fb_pend};
      default:            rbyte = 8'h00;
    endcase
  end

  // One wait state: pready rises in the first access cycle's edge
  always_comb begin
    next_pready  = i_psel && i_penable && !o_pready;
    next_prdata  = 32'h0000_0000;
    next_pslverr = 1'b0;
    if (next_pready) begin
      next_prdata  = (hit && !i_pwrite) ? {24'h000000, rbyte} :
                     32'h0000_0000;
      next_pslverr = !hit;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pready  <= 1'b0;
      o_prdata  <= 32'h0000_0000;
      o_pslverr <= 1'b0;
    end else begin
      o_pready  <= next_pready;
      o_prdata  <= next_prdata;
      o_pslverr <= next_pslverr;
    end
  end

  // ----------------------------------------------------------------------
  // Core settings
  // ----------------------------------------------------------------------
  pdfc_core_t  next_core;
  logic [2:0]  order;
  logic [4:0]  gain;
  logic [11:0] gain_w;

  assign order  = fb_stage[16 + `PDFC_ORDER_LSB +: 3];
  assign gain   = pump[`PDFC_GAIN_MSB:0];
  assign gain_w = {7'h00, gain};

  // Modulator and option fields act at once; wide fields only on commit
  always_comb begin
    next_core = o_core;
    next_core.feedback_divide =
      fb_value[16 + `PDFC_FB_HI_MSB:0];
    next_core.ramp_start =
      wr && (idx == `PDFC_IDX_FB_LOW);
    next_core.modulator_dither_level =
      pdfc_dither_t'(fb_stage[16 + `PDFC_DITHER_LSB +: 2]);
    next_core.dither_enable =
      fb_stage[16 + `PDFC_DITHER_LSB +: 2] != PDFC_DITHER_OFF;
    next_core.modulator_order_select = order;
    next_core.integer_mode   = (order == 3'h0);
    next_core.order_reserved = (order > `PDFC_ORDER_MAX);
    next_core.fraction_numerator = num_value;
    // Ramp mode ignores the programmed denominator
    next_core.fraction_denominator =
      ramp_ctl[`PDFC_RAMP_EN_BIT] ? `PDFC_RAMP_DEN :
                                    {1'b0, den_value};
    next_core.reference_divide = ref_value;
    next_core.reference_bypass =
      (ref_value == `PDFC_RST_REF);
    next_core.reference_doubler_enable =
      ref_opt[`PDFC_DOUBLER_BIT];
    // Divide range in differential mode is left to software
    next_core.differential_reference_counter =
      ref_opt[`PDFC_DIFF_BIT];
    next_core.detector_min_pulse_width =
      ref_opt[`PDFC_PULSE_LSB +: 2];
    next_core.pulse_width_ps =
      pdfc_pulse_ps(ref_opt[`PDFC_PULSE_LSB +: 2]);
    next_core.pulse_width_reserved =
      (ref_opt[`PDFC_PULSE_LSB +: 2] == 2'h0);
    next_core.pump_current_gain = gain;
    next_core.pump_current_ua =
      12'(gain_w * `PDFC_PUMP_STEP_UA);
    next_core.pump_tristate = (gain == 5'h00);
    next_core.pump_polarity_negative =
      pump[`PDFC_POLARITY_BIT];
  end

  // Reset image matches the register defaults
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_core                          <= '0;
      o_core.feedback_divide          <= 18'(`PDFC_RST_FB);
      o_core.dither_enable            <= 1'b1;
      o_core.integer_mode             <= 1'b1;
      o_core.reference_divide         <= `PDFC_RST_REF;
      o_core.reference_bypass         <= 1'b1;
      o_core.detector_min_pulse_width <= 2'h1;
      o_core.pulse_width_ps           <= `PDFC_PULSE_PS_1;
      o_core.pump_tristate            <= 1'b1;
    end else begin
      o_core <= next_core;
    end
  end

endmodule : pdfc_top

`default_nettype wire

// File: sim/pdfc_checker.sv
// Bus timing and core decode assertions for the divider register bank
`timescale 1ns/10ps
`default_nettype none

module pdfc_checker
  import pdfc_pkg::*;
(
  // Clock and reset
  input wire logic             i_clk,
  input wire logic             i_rst_n,
  // Register bus
  input wire logic             i_psel,
  input wire logic             i_penable,
  input wire logic             i_pwrite,
  input wire logic [11:0]      i_paddr,
  input wire logic [31:0]      i_pwdata,
  input wire logic             o_pready,
  input wire logic [31:0]      o_prdata,
  input wire logic             o_pslverr,
  // Core settings
  input wire pdfc_pkg::pdfc_core_t o_core
);
  // Completed transfer and short field aliases
  logic       done;
  logic [1:0] pc;
  logic [2:0] ord;
  logic [4:0] gn;
  assign done = i_psel && i_penable && o_pready;
  assign pc   = o_core.detector_min_pulse_width;
  assign ord  = o_core.modulator_order_select;
  assign gn   = o_core.pump_current_gain;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);

  chk_apb_wait: assert property (i_psel && !i_penable |=>
    i_penable && !o_pready ##1 o_pready) else $error("pready timing off");
  chk_ready_pulse: assert property (o_pready |=> !o_pready)
    else $error("pready held");
  chk_err_data: assert property (o_pslverr |-> o_pready && o_prdata == 32'h0)
    else $error("error reply not clean");
  chk_rd_upper: assert property (o_pready |-> o_prdata[31:8] == 24'h0)
    else $error("upper read bits set");
  chk_ramp_pulse: assert property (
    done && i_pwrite && i_paddr == 12'h040 |=> o_core.ramp_start
    ##1 !o_core.ramp_start) else $error("ramp start pulse wrong");
  chk_ramp_cause: assert property ($rose(o_core.ramp_start) |->
    $past(done && i_pwrite && i_paddr == 12'h040))
    else $error("ramp start without low byte write");
  chk_ramp_den: assert property (o_core.fraction_denominator[24] |->
    o_core.fraction_denominator[23:0] == 24'h0) else $error("bad ramp den");
  chk_order_dec: assert property (o_core.integer_mode == (ord == 3'h0) &&
    o_core.order_reserved == (ord > 3'h4)) else $error("order decode");
  chk_dither_dec: assert property (o_core.dither_enable ==
    (o_core.modulator_dither_level != PDFC_DITHER_OFF))
    else $error("dither decode");
  chk_ref_bypass: assert property (o_core.reference_bypass ==
    (o_core.reference_divide == 16'h0001)) else $error("bypass decode");
  chk_pulse_dec: assert property (o_core.pulse_width_ps == (pc == 2'h1 ?
    11'h35c : pc == 2'h2 ? 11'h4b0 : pc == 2'h3 ? 11'h5dc : 11'h000))
    else $error("pulse width decode");
  chk_pump_dec: assert property (o_core.pump_current_ua ==
    {7'h00, gn} * 12'h064 && o_core.pump_tristate == (gn == 5'h00))
    else $error("pump gain decode");
  chk_software_register_reset_def: assert property (done && i_pwrite &&
    i_paddr == 12'h008 && i_pwdata[2] |=> ##1 o_core.feedback_divide ==
    18'h00010 && o_core.reference_divide == 16'h0001 && pc == 2'h1)
    else $error("soft reset defaults missing");

  // Main scenarios reached
  cov_ramp: cover property (o_core.ramp_start);
  cov_err: cover property (o_pslverr);
  cov_den: cover property (o_core.fraction_denominator[24]);
endmodule : pdfc_checker

bind pdfc_top pdfc_checker u_chk (.i_clk(i_clk), .i_rst_n(i_rst_n),
  .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
  .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_pready(o_pready),
  .o_prdata(o_prdata), .o_pslverr(o_pslverr), .o_core(o_core));

`default_nettype wire

// File: sim/tb.sv
// Self-checking bench for the divider register bank against a model
`timescale 1ns/10ps
`default_nettype none

module tb;
  import pdfc_pkg::*;
  // ------------------------------------------------------------
  // Stimulus, model state, counters
  // ------------------------------------------------------------
  logic        i_clk, i_rst_n, psel, penable, pwrite, pready, pslverr, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, r;
  pdfc_core_t  core;
  logic [7:0]  mdl [0:255];
  logic [23:0] com [0:3];
  logic [2:0]  pend [0:3];
  int          num_errors, checks_done, cycles, seed, i;

  pdfc_top dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_pready(pready), .o_prdata(prdata),
    .o_pslverr(pslverr), .o_core(core));

  // 25 MHz clock
  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end

  // Hang guard, far above the few thousand cycles the run needs
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      conclude();
    end
  end

  task conclude;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : conclude

  task cmp_val(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp_val

  task cmp_core(input pdfc_core_t got, input pdfc_core_t exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp_core

  // ------------------------------------------------------------
  // Reference model
  // ------------------------------------------------------------
  task mreset;
    for (int k = 0; k < 256; k++) mdl[k] = 8'h00;
    mdl[8'h10] = 8'h10;
    mdl[8'h19] = 8'h01;
    mdl[8'h1b] = 8'h08;
    com = '{24'h000010, 24'h000000, 24'h000000, 24'h000001};
    pend = '{3'h0, 3'h0, 3'h0, 3'h0};
  endtask : mreset

  // Undocumented bits are never written, so no guess about them is made
  function automatic logic [7:0] msk(input logic [7:0] x);
    case (x)
      8'h12: return 8'h7f;
      8'h1b: return 8'h1d;
      8'h1c: return 8'h3f;
      8'h20: return 8'h01;
      default: return 8'hff;
    endcase
  endfunction : msk

  function automatic logic merr(input logic [7:0] x);
    return !(x == 8'h02 || (x >= 8'h10 && x <= 8'h1c) || x >= 8'h20
      && x <= 8'h21);
  endfunction : merr

  function automatic logic [31:0] mrd(input logic [7:0] x);
    if (x == 8'h21) return {28'h0, pend[3] != 3'h0, pend[2] != 3'h0,
      pend[1] != 3'h0, pend[0] != 3'h0};
    if (merr(x) || x == 8'h02) return 32'h0;
    return {24'h0, mdl[x]};
  endfunction : mrd

  // Staged bytes, committed only once a field is complete
  task mwr(input logic [7:0] x, input logic [7:0] v);
    int b;
    b = (x - 16) / 3 * 3 + 16;
    if (x == 8'h02 && v[2]) mreset();
    else if (!merr(x) && x != 8'h21 && x != 8'h02) begin
      mdl[x] = v & msk(x);
      if (x <= 8'h1a) begin
        pend[(x - 16) / 3][(x - 16) % 3] = 1'b1;
        if (pend[(x - 16) / 3] == (x >= 8'h19 ? 3'h3 : 3'h7)) begin
          pend[(x - 16) / 3] = 3'h0;
          com[(x - 16) / 3] = {x >= 8'h19 ? 8'h00 : mdl[b + 2],
            mdl[b + 1], mdl[b]};
        end
      end
    end
  endtask : mwr

  function automatic pdfc_core_t mexp();
    pdfc_core_t e;
    logic [7:0] h, o, p;
    h = mdl[8'h12];
    o = mdl[8'h1b];
    p = mdl[8'h1c];
    e = '0;
    e.feedback_divide = com[0][17:0];
    e.modulator_dither_level = pdfc_dither_t'(h[3:2]);
    e.dither_enable = h[3:2] != 2'h3;
    e.modulator_order_select = h[6:4];
    e.integer_mode = h[6:4] == 3'h0;
    e.order_reserved = h[6:4] > 3'h4;
    e.fraction_numerator = com[1];
    e.fraction_denominator = mdl[8'h20][0] ? 25'h1000000 : {1'b0, com[2]};
    e.reference_divide = com[3][15:0];
    e.reference_bypass = com[3][15:0] == 16'h0001;
    e.reference_doubler_enable = o[0];
    e.differential_reference_counter = o[2];
    e.detector_min_pulse_width = o[4:3];
    e.pulse_width_ps = o[4:3] == 2'h1 ? 11'h35c : o[4:3] == 2'h2 ?
      11'h4b0 : o[4:3] == 2'h3 ? 11'h5dc : 11'h000;
    e.pulse_width_reserved = o[4:3] == 2'h0;
    e.pump_current_gain = p[4:0];
    e.pump_current_ua = p[4:0] * 12'h064;
    e.pump_tristate = p[4:0] == 5'h00;
    e.pump_polarity_negative = p[5];
    return e;
  endfunction : mexp

  // ------------------------------------------------------------
  // Bus tasks
  // ------------------------------------------------------------
  task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    logic [31:0] n;
    n = $random(seed);
    @(posedge i_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {n[31:8], d};
    @(posedge i_clk);
    penable <= 1'b1;
    do @(posedge i_clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task rchk(input logic [7:0] x);
    apb(1'b0, {2'h0, x, 2'h0}, 8'h00);
    cmp_val(rd, mrd(x));
    cmp_val({31'h0, er}, {31'h0, merr(x)});
  endtask : rchk

  // Write, then check pulse, core settings one edge on, and readback
  task wr(input logic [7:0] x, input logic [7:0] v);
    apb(1'b1, {2'h0, x, 2'h0}, v);
    mwr(x, v);
    #1;
    if (x == 8'h10) cmp_val({31'h0, core.ramp_start}, 32'h1);
    @(posedge i_clk);
    #1;
    cmp_core(core, mexp());
    rchk(x);
  endtask : wr

  task allchk;
    cmp_core(core, mexp());
    for (int k = 8'h02; k <= 8'h21; k++) rchk(k[7:0]);
  endtask : allchk

  task rnd_traffic(input int n);
    int j;
    logic [7:0] a;
    repeat (n) begin
      r = $random(seed);
      j = r[15:8] % 15;
      a = 8'(j >= 13 ? 8'h20 + j - 13 : 8'h10 + j);
      wr(a, r[7:0] & msk(a) & (a == 8'h1b ? 8'hfb : 8'hff));
    end
  endtask : rnd_traffic

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {num_errors, checks_done, cycles} = '0;
    seed = 74;
    i_rst_n = 1'b0;
    mreset();
    repeat (4) @(posedge i_clk);
    i_rst_n <= 1'b1;
    allchk();
    // Misaligned write hits nothing and starts no ramp
    apb(1'b1, 12'h041, 8'h5a);
    #1;
    cmp_val({31'h0, er}, 32'h1);
    cmp_val({31'h0, core.ramp_start}, 32'h0);
    rchk(8'h10);
    // Feedback bytes out of order: held until the last byte lands
    wr(8'h11, 8'h23);
    wr(8'h12, 8'h13);
    wr(8'h10, 8'h45);
    // Every order, dither, pulse width and pump gain code
    for (i = 0; i < 32; i++) wr(8'h12, {1'b0, i[4:0], 2'h2});
    for (i = 0; i < 4; i++) begin
      r = $random(seed);
      wr(8'h1b, {3'h0, i[1:0], r[2], 1'b0, r[0]});
    end
    wr(8'h1b, 8'h08);
    for (i = 0; i < 32; i++) begin
      r = $random(seed);
      wr(8'h1c, {2'h0, r[5], i[4:0]});
    end
    // Bypass value, then a divide of four
    wr(8'h19, 8'h01);
    wr(8'h1a, 8'h00);
    wr(8'h19, 8'h04);
    wr(8'h1a, 8'h00);
    // Ramp mode hides the programmed denominator
    wr(8'h20, 8'h01);
    for (i = 8'h16; i <= 8'h18; i++) wr(i[7:0], 8'($random(seed)));
    wr(8'h20, 8'h00);
    rnd_traffic(60);
    // Hardware reset in mid-run
    @(posedge i_clk);
    i_rst_n <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_rst_n <= 1'b1;
    mreset();
    allchk();
    rnd_traffic(40);
    wr(8'h02, 8'h04);
    allchk();
    conclude();
  end
endmodule : tb

`default_nettype wire
